/* File: rtl/port_mux_pkg.sv */
package port_mux_pkg;

  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;

  // Register indices on the plain register port
  localparam logic [3:0] OFS_DATA_LATCH   = 4'h0;
  localparam logic [3:0] OFS_DIRECTION    = 4'h1;
  localparam logic [3:0] OFS_PULL_HIGH    = 4'h2;
  localparam logic [3:0] OFS_WAKEUP       = 4'h3;
  localparam logic [3:0] OFS_FUNC_SELECT  = 4'h4;
  localparam logic [3:0] OFS_BIT_SET      = 4'h5;
  localparam logic [3:0] OFS_BIT_CLEAR    = 4'h6;
  localparam logic [3:0] OFS_POWER_STATUS = 4'h7;

  // Bit operation word: target register select and bit index
  localparam int unsigned BITOP_TGT_POS = 4;
  localparam int unsigned BITOP_IDX_LSB = 0;
  localparam logic [1:0]  BITOP_TGT_DATA = 2'h0;
  localparam logic [1:0]  BITOP_TGT_DIR  = 2'h1;
  localparam logic [1:0]  BITOP_TGT_PULL = 2'h2;
  localparam logic [1:0]  BITOP_TGT_WAKE = 2'h3;

  localparam logic [7:0] RST_FUNC_SELECT = 8'h00;
  localparam logic [3:0] RST_DATA_LATCH  = 4'hf;
  localparam logic [3:0] RST_DIRECTION   = 4'hf;
  localparam logic [3:0] RST_PULL_HIGH   = 4'h0;
  localparam logic [3:0] RST_WAKEUP      = 4'h0;

  localparam int unsigned FIELD_W = 2;

  typedef enum logic [1:0] {
    FSEL_GPIO  = 2'b00,
    FSEL_ALT_A = 2'b01,
    FSEL_ALT_B = 2'b10,
    FSEL_ALT_C = 2'b11
  } fsel_t;

  // Peripheral outputs offered per pin for each alternative code
  typedef struct packed {
    logic [3:0] alt_a;
    logic [3:0] alt_b;
    logic [3:0] alt_c;
  } periph_out_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] pull_en;
  } pin_drive_t;

endpackage

/* File: rtl/pin_cell.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_cell (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [1:0] fsel,
  input  wire logic       dir_in,
  input  wire logic       latch,
  input  wire logic       pull_req,
  input  wire logic       wake_en,
  input  wire logic       low_power,
  input  wire logic       alt_a,
  input  wire logic       alt_b,
  input  wire logic       alt_c,
  input  wire logic       pin_sync,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            pad_pull,
  output logic            digital_in,
  output logic            wake_hit
);

  logic gpio_sel;
  logic pin_prev_r;

  assign gpio_sel = (port_mux_pkg::fsel_t'(fsel) == port_mux_pkg::FSEL_GPIO);

  always_comb begin
    case (port_mux_pkg::fsel_t'(fsel))
      port_mux_pkg::FSEL_GPIO: begin
        pad_out = latch;
        pad_oe  = ~dir_in;
      end
      port_mux_pkg::FSEL_ALT_A: begin
        pad_out = alt_a;
        pad_oe  = 1'b1;
      end
      port_mux_pkg::FSEL_ALT_B: begin
        pad_out = alt_b;
        pad_oe  = 1'b1;
      end
      port_mux_pkg::FSEL_ALT_C: begin
        pad_out = alt_c;
        pad_oe  = 1'b1;
      end
      default: begin
        pad_out = latch;
        pad_oe  = 1'b0;
      end
    endcase
  end

  assign digital_in = gpio_sel & dir_in & pin_sync;

  assign pad_pull = pull_req & gpio_sel & dir_in;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_prev_r <= 1'b1;
    end else begin
      pin_prev_r <= pin_sync;
    end
  end

  assign wake_hit = wake_en & low_power & gpio_sel & dir_in & pin_prev_r & ~pin_sync;

endmodule
`default_nettype wire

/* File: rtl/port_pin_function_select.sv */
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_select #(
  parameter int unsigned PINS = port_mux_pkg::PIN_COUNT
) (
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  input  wire logic [port_mux_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [port_mux_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [port_mux_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                              low_power,
  input  wire port_mux_pkg::periph_out_t         periph_out,
  input  wire logic [PINS-1:0]                   pad_in,
  output port_mux_pkg::pin_drive_t               pad_drive,
  output logic      [PINS-1:0]                   func_in,
  output logic                                   wake_req
);

  logic [7:0]      func_select_r;
  logic [PINS-1:0] data_latch_r;
  logic [PINS-1:0] direction_r;
  logic [PINS-1:0] pull_high_r;
  logic [PINS-1:0] wakeup_r;
  logic [PINS-1:0] pad_meta_r;
  logic [PINS-1:0] pad_sync_r;
  logic [PINS-1:0] port_view;
  logic [PINS-1:0] cell_out;
  logic [PINS-1:0] cell_oe;
  logic [PINS-1:0] cell_pull;
  logic [PINS-1:0] cell_din;
  logic [PINS-1:0] cell_wake;
  logic            bitop;
  logic            bit_val;
  logic [1:0]      bit_tgt;
  logic [1:0]      bit_idx;
  logic [PINS-1:0] rmw_src;
  logic [PINS-1:0] rmw_res;
  logic [7:0]      rdata_nxt;

  // Replaces one bit; caller supplies the whole word
  function automatic logic [PINS-1:0] set_bit(input logic [PINS-1:0] word,
                                              input logic [1:0] idx,
                                              input logic val);
    logic [PINS-1:0] res;
    res = word;
    res[idx] = val;
    return res;
  endfunction

  // Pins are asynchronous, so two flops come before any logic
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pad_meta_r <= '0;
      pad_sync_r <= '0;
    end else begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
    end
  end

  assign port_view = (direction_r & pad_sync_r) | (~direction_r & data_latch_r);

  // Set and clear share one decode; the address picks the value
  assign bitop   = reg_wr & ((reg_addr == port_mux_pkg::OFS_BIT_SET) |
                             (reg_addr == port_mux_pkg::OFS_BIT_CLEAR));
  assign bit_val = (reg_addr == port_mux_pkg::OFS_BIT_SET);
  assign bit_tgt = reg_wdata[port_mux_pkg::BITOP_TGT_POS +: 2];
  assign bit_idx = reg_wdata[port_mux_pkg::BITOP_IDX_LSB +: 2];

  // whole port read for bit ops on the data latch; other targets read their own register
  always_comb begin
    case (bit_tgt)
      port_mux_pkg::BITOP_TGT_DATA: rmw_src = port_view;
      port_mux_pkg::BITOP_TGT_DIR:  rmw_src = direction_r;
      port_mux_pkg::BITOP_TGT_PULL: rmw_src = pull_high_r;
      port_mux_pkg::BITOP_TGT_WAKE: rmw_src = wakeup_r;
      default:                      rmw_src = '0;
    endcase
  end
  assign rmw_res = set_bit(rmw_src, bit_idx, bit_val);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      func_select_r <= port_mux_pkg::RST_FUNC_SELECT;
    end else if (reg_wr && reg_addr == port_mux_pkg::OFS_FUNC_SELECT) begin
      func_select_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_latch_r <= port_mux_pkg::RST_DATA_LATCH;
    end else if (reg_wr && reg_addr == port_mux_pkg::OFS_DATA_LATCH) begin
      data_latch_r <= reg_wdata[PINS-1:0];
    end else if (bitop && bit_tgt == port_mux_pkg::BITOP_TGT_DATA) begin
      data_latch_r <= rmw_res;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      direction_r <= port_mux_pkg::RST_DIRECTION;
    end else if (reg_wr && reg_addr == port_mux_pkg::OFS_DIRECTION) begin
      direction_r <= reg_wdata[PINS-1:0];
    end else if (bitop && bit_tgt == port_mux_pkg::BITOP_TGT_DIR) begin
      direction_r <= rmw_res;
    end
  end

  // Pull-high enable, byte or bit access
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pull_high_r <= port_mux_pkg::RST_PULL_HIGH;
    end else if (reg_wr && reg_addr == port_mux_pkg::OFS_PULL_HIGH) begin
      pull_high_r <= reg_wdata[PINS-1:0];
    end else if (bitop && bit_tgt == port_mux_pkg::BITOP_TGT_PULL) begin
      pull_high_r <= rmw_res;
    end
  end

  // Wake enable, byte or bit access
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wakeup_r <= port_mux_pkg::RST_WAKEUP;
    end else if (reg_wr && reg_addr == port_mux_pkg::OFS_WAKEUP) begin
      wakeup_r <= reg_wdata[PINS-1:0];
    end else if (bitop && bit_tgt == port_mux_pkg::BITOP_TGT_WAKE) begin
      wakeup_r <= rmw_res;
    end
  end

  // One cell per pin: mux, input gating and edge detect
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      pin_cell u_cell (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .fsel       (func_select_r[g*port_mux_pkg::FIELD_W +: 2]),
        .dir_in     (direction_r[g]),
        .latch      (data_latch_r[g]),
        .pull_req   (pull_high_r[g]),
        .wake_en    (wakeup_r[g]),
        .low_power  (low_power),
        .alt_a      (periph_out.alt_a[g]),
        .alt_b      (periph_out.alt_b[g]),
        .alt_c      (periph_out.alt_c[g]),
        .pin_sync   (pad_sync_r[g]),
        .pad_out    (cell_out[g]),
        .pad_oe     (cell_oe[g]),
        .pad_pull   (cell_pull[g]),
        .digital_in (cell_din[g]),
        .wake_hit   (cell_wake[g])
      );
    end
  endgenerate

  // Registered so pad changes never glitch from decode logic
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pad_drive <= '{out: port_mux_pkg::RST_DATA_LATCH, oe: 4'h0,
                     pull_en: port_mux_pkg::RST_PULL_HIGH};
      func_in   <= '0;
      wake_req  <= 1'b0;
    end else begin
      pad_drive <= '{out: cell_out, oe: cell_oe, pull_en: cell_pull};
      func_in   <= cell_din;
      wake_req  <= |cell_wake;
    end
  end

  // Unmapped and write-only indices read as zero
  always_comb begin
    case (reg_addr)
      port_mux_pkg::OFS_DATA_LATCH:   rdata_nxt = {4'h0, port_view};
      port_mux_pkg::OFS_DIRECTION:    rdata_nxt = {4'h0, direction_r};
      port_mux_pkg::OFS_PULL_HIGH:    rdata_nxt = {4'h0, pull_high_r};
      port_mux_pkg::OFS_WAKEUP:       rdata_nxt = {4'h0, wakeup_r};
      port_mux_pkg::OFS_FUNC_SELECT:  rdata_nxt = func_select_r;
      port_mux_pkg::OFS_POWER_STATUS: rdata_nxt = {7'h00, low_power};
      default:                        rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands one cycle; zero otherwise keeps the bus quiet
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* File: bench/port_pin_function_select_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_select_checker #(
  parameter int unsigned PINS = 4
) (
  input wire logic                      clk_sys,
  input wire logic                      nrst,
  input wire logic [3:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      low_power,
  input wire port_mux_pkg::periph_out_t periph_out,
  input wire logic [PINS-1:0]           pad_in,
  input wire port_mux_pkg::pin_drive_t  pad_drive,
  input wire logic [PINS-1:0]           func_in,
  input wire logic                      wake_req
);
  logic [7:0] sel_r;
  logic [1:0] age_r;
  // Shadow select and cycles since its last write, so settled outputs can be judged
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sel_r <= 8'h00;
      age_r <= 2'h0;
    end else if (reg_wr && reg_addr == port_mux_pkg::OFS_FUNC_SELECT) begin
      sel_r <= reg_wdata;
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end
  function automatic logic alt0(input logic [1:0] c, input port_mux_pkg::periph_out_t p);
    return c == 2'b01 ? p.alt_a[0] : c == 2'b10 ? p.alt_b[0] : p.alt_c[0];
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence dir_wr_s;
    reg_wr && reg_addr == 4'h1 && sel_r == 8'h00;
  endsequence
  sequence alt0_s;
    age_r == 2'h3 && sel_r[1:0] != 2'b00;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) < 4'h4 |-> reg_rdata[7:4] == 4'h0)
    else $error("upper read bits of port register not zero");
  a_reset_drive: assert property (!$past(nrst) |-> pad_drive.out == 4'hf && pad_drive.oe == 4'h0)
    else $error("pins not inputs with high latch after reset");
  a_dir_oe: assert property (dir_wr_s |-> ##2 pad_drive.oe == ~$past(reg_wdata[3:0], 2))
    else $error("direction write not reflected in output enables");
  a_alt_drive: assert property (alt0_s |-> pad_drive.oe[0] && pad_drive.out[0] == alt0(sel_r[1:0], $past(periph_out)))
    else $error("pin0 not driven by selected peripheral");
  a_alt_quiet: assert property (alt0_s |-> !pad_drive.pull_en[0] && !func_in[0])
    else $error("pin0 pull or input function active under peripheral code");
  a_pull_excl: assert property ((pad_drive.oe & pad_drive.pull_en) == 4'h0)
    else $error("pull-high on a driven pin");
  a_wake_gate: assert property (wake_req |-> $past(low_power))
    else $error("wake request outside low power");
endmodule
bind port_pin_function_select port_pin_function_select_checker #(.PINS(PINS)) i_chk (.clk_sys,
  .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .low_power, .periph_out, .pad_in,
  .pad_drive, .func_in, .wake_req);
`default_nettype wire

/* File: bench/pin_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input  wire logic                     clk_sys,
  input  wire port_mux_pkg::pin_drive_t drv,
  input  wire logic [3:0]               ext_val,
  input  wire logic [3:0]               ext_en,
  output logic      [3:0]               pin
);
  // Open line wanders so a stale level never passes for data
  logic [3:0] flt_r = 4'h5;
  always @(posedge clk_sys) flt_r <= ~flt_r;
  // push-pull driver wins, then circuit, then pull-up
  assign pin = (drv.oe & drv.out) | (~drv.oe & ext_en & ext_val)
             | (~drv.oe & ~ext_en & (drv.pull_en | flt_r));
endmodule
`default_nettype wire

/* File: bench/tb_port_pin_function_select.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_port_pin_function_select;
  logic                      clk_sys = 1'b0;
  logic                      nrst = 1'b0;
  logic [3:0]                reg_addr = 4'h0;
  logic [7:0]                reg_wdata = 8'h00;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic                      low_power = 1'b0;
  port_mux_pkg::periph_out_t periph_out = 12'h000;
  logic [7:0]                reg_rdata;
  logic [3:0]                pad_in, func_in, pinx, xd;
  logic                      wake_req;
  port_mux_pkg::pin_drive_t  pad_drive, e;
  logic [3:0]                ext_val = 4'ha, ext_en = 4'hf;
  logic [3:0]                m_lat = 4'hf, m_dir = 4'hf, m_pul = 4'h0, m_wak = 4'h0;
  logic [7:0]                m_sel = 8'h00;
  int                        bad_count = 0, total_checks = 0, cyc = 0, wakes = 0;
  int unsigned               rs = 60;
  port_pin_function_select i_port_pin_function_select (.clk_sys, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .low_power, .periph_out, .pad_in, .pad_drive, .func_in,
    .wake_req);
  pin_partner i_pin_partner (.clk_sys, .drv(pad_drive), .ext_val, .ext_en, .pin(pad_in));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    wakes <= wakes + int'(wake_req === 1'b1);
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end
  function automatic int unsigned xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] x);
    logic [7:0] v;
    rd(a, v);
    cmp({4'h0, v}, {4'h0, x}, "read");
  endtask
  // Write and keep the model in step; bit ops on the data latch re-read the whole port first
  task automatic wm(input logic [3:0] a, input logic [7:0] v);
    logic [3:0] b;
    wr(a, v);
    b = 4'h1 << v[1:0];
    case (a)
      4'h0: m_lat = v[3:0];
      4'h1: m_dir = v[3:0];
      4'h2: m_pul = v[3:0];
      4'h3: m_wak = v[3:0];
      4'h4: m_sel = v;
      default: begin
        if (v[5:4] == 2'h0) m_lat = (m_dir & pinx) | (~m_dir & m_lat);
        case (v[5:4])
          2'h0: m_lat = a[0] ? m_lat | b : m_lat & ~b;
          2'h1: m_dir = a[0] ? m_dir | b : m_dir & ~b;
          2'h2: m_pul = a[0] ? m_pul | b : m_pul & ~b;
          default: m_wak = a[0] ? m_wak | b : m_wak & ~b;
        endcase
      end
    endcase
  endtask
  task automatic mdl(output logic [3:0] fx);
    logic [1:0] f;
    for (int i = 0; i < 4; i++) begin
      f = m_sel[2*i +: 2];
      e.out[i] = f == 2'd0 ? m_lat[i] : f == 2'd1 ? periph_out.alt_a[i]
               : f == 2'd2 ? periph_out.alt_b[i] : periph_out.alt_c[i];
      e.oe[i] = f != 2'd0 || !m_dir[i];
      e.pull_en[i] = f == 2'd0 && m_dir[i] && m_pul[i];
      pinx[i] = e.oe[i] ? e.out[i] : e.pull_en[i] | ext_val[i];
      fx[i] = f == 2'd0 && m_dir[i] && pinx[i];
      xd[i] = m_dir[i] ? pinx[i] : m_lat[i];
    end
  endtask
  task automatic chk_pins();
    logic [3:0] fx;
    logic [7:0] v;
    @(posedge clk_sys);
    mdl(fx);
    ext_en <= ~(e.oe | e.pull_en);
    tick(6);
    rd(4'h0, v);
    cmp({4'h0, v}, {8'h00, xd}, "data");
    #1;
    cmp(pad_drive, e, "drive");
    cmp({8'h00, func_in}, {8'h00, fx}, "func");
    @(posedge clk_sys);
  endtask
  task automatic chk_wake(input logic [3:0] fall, input int n);
    int w0;
    ext_val <= 4'hf;
    wm(4'h0, 8'h0f);
    tick(8);
    w0 = wakes;
    ext_val <= ~fall;
    // Output pins fall through the latch, so direction gating is seen
    wm(4'h0, {4'h0, ~fall});
    tick(8);
    cmp(12'(wakes - w0), 12'(n), "wake");
  endtask
  initial begin
    tick(10);
    nrst <= 1'b1;
    tick(4);
    chk_pins();
    chk_rd(4'h1, 8'h0f);
    chk_rd(4'h2, 8'h00);
    chk_rd(4'h3, 8'h00);
    chk_rd(4'h4, 8'h00);
    chk_rd(4'h9, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wm(4'h6, {6'h04, i[1:0]});
      chk_pins();
    end
    wm(4'h5, 8'h12);
    wm(4'h5, 8'h13);
    chk_pins();
    wm(4'h6, 8'h00);
    chk_pins();
    wm(4'h1, 8'h00);
    chk_pins();
    for (int i = 0; i < 16; i++) begin
      wm(4'h4, {8'(xs()) & 8'hfc | 8'(i % 4)});
      wm(4'h1, 8'(xs()));
      wm(4'h0, 8'(xs()));
      wm(4'h2, 8'(xs()));
      periph_out <= 12'(xs());
      ext_val <= 4'(xs());
      chk_pins();
      chk_rd(4'h4, m_sel);
      periph_out <= 12'h000;
    end
    ext_en <= 4'hf;
    wm(4'h2, 8'h00);
    wm(4'h4, 8'h00);
    wm(4'h5, 8'h21);
    chk_rd(4'h2, 8'h02);
    wm(4'h6, 8'h21);
    wm(4'h1, 8'h0b);
    wm(4'h3, 8'h0f);
    wm(4'h6, 8'h33);
    chk_rd(4'h3, 8'h07);
    low_power <= 1'b1;
    chk_rd(4'h7, 8'h01);
    chk_wake(4'h1, 1);
    chk_wake(4'h2, 1);
    chk_wake(4'h8, 0);
    chk_wake(4'h4, 0);
    low_power <= 1'b0;
    chk_wake(4'h1, 0);
    test_done();
  end
endmodule
`default_nettype wire
